//--- tb/biw_bank_asserts.sv
// assertion checker for the I/O window and downstream status bank ports
`timescale 1ns/10ps
`default_nettype none
module biw_bank_chk
  import biw_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pslverr_o,
  input  wire logic        io_req_valid_i,
  input  wire logic [31:0] io_req_addr_i,
  input  wire logic        io_fwd_valid_o,
  input  wire logic        io_fwd_hit_o,
  input  wire logic [31:0] io_base_o,
  input  wire logic [31:0] io_limit_o,
  input  wire logic        parity_resp_en_o,
  input  wire logic        system_error_report_enable_o
);
  logic acc;
  logic wr_stat;
  assign acc = psel_i && penable_i;
  assign wr_stat = acc && pwrite_i && (paddr_i == OFS_IO_STATUS);

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // bit 24 is a live flag, so only 26:25 and 23:16 are held at zero here
  a_status_const: assert property (
    acc && !pwrite_i && paddr_i == OFS_IO_STATUS
    |-> (prdata_o & 32'h06ff_0f0f) == 32'h0000_0101 && !pslverr_o)
    else $error("constant status fields wrong");
  a_base_low_zero: assert property (io_base_o[11:0] == 12'h000)
    else $error("lower bound low bits not zero");
  a_limit_low_ones: assert property ($past(rst_n_i) |-> io_limit_o[11:0] == 12'hfff)
    else $error("upper bound low bits not ones");
  // the release edge itself starts no attempt: the bounds leave reset on the edge after it
  a_bounds_steady: assert property (rst_n_i && !(acc && pwrite_i) |=> ##1
    $stable(io_base_o) && $stable(io_limit_o)) else $error("bounds moved without a write");
  a_base_nib_write: assert property (wr_stat && pstrb_i[0] |=> ##1
    io_base_o[15:12] == $past(pwdata_i[7:4], 2)) else $error("base nibble not taken");
  a_limit_nib_write: assert property (wr_stat && pstrb_i[1] |=> ##1
    io_limit_o[15:12] == $past(pwdata_i[15:12], 2)) else $error("limit nibble not taken");
  a_fwd_follows_req: assert property ($past(rst_n_i) |->
    io_fwd_valid_o == $past(io_req_valid_i)) else $error("lookup answer timing wrong");
  a_fwd_hit_range: assert property (io_fwd_valid_o |-> io_fwd_hit_o ==
    ($past(io_req_addr_i) >= io_base_o && $past(io_req_addr_i) <= io_limit_o))
    else $error("forward decision wrong");
  a_enable_write: assert property (
    acc && pwrite_i && paddr_i == OFS_BRG_CTRL && pstrb_i[2]
    |=> parity_resp_en_o == $past(pwdata_i[CTRL_PERR_EN_POS])
    && system_error_report_enable_o == $past(pwdata_i[CTRL_SERR_EN_POS]))
    else $error("enable bits not taken");

  c_hit: cover property (io_fwd_valid_o && io_fwd_hit_o);
  c_unmapped: cover property (acc && pslverr_o);
  c_w1c_lane: cover property (wr_stat && pstrb_i == 4'h8);
endmodule // biw_bank_chk
`default_nettype wire

//--- tb/biw_far_side.sv
// far-side model: secondary transaction logic raising events and I/O lookups
`timescale 1ns/10ps
`default_nettype none
module biw_far_side (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [5:0]  fire_i,
  input  wire logic        look_i,
  input  wire logic [31:0] look_addr_i,
  output var  logic [5:0]  evt_o,
  output var  logic        io_req_valid_o,
  output var  logic [31:0] io_req_addr_o
);
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_o          <= 6'h00;
      io_req_valid_o <= 1'b0;
      io_req_addr_o  <= 32'h0000_0000;
    end else begin
      evt_o          <= fire_i;
      io_req_valid_o <= look_i;
      // address is not held between lookups, so toggle it
      io_req_addr_o  <= look_i ? look_addr_i : ~io_req_addr_o;
    end
  end
endmodule // biw_far_side
`default_nettype wire

//--- tb/tb_top.sv
// testbench for the I/O window and downstream status bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import biw_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic [3:0]  pstrb      = 4'h0;
  logic [5:0]  fire       = 6'h00;
  logic        look       = 1'b0;
  logic [31:0] look_addr  = 32'h0000_0000;
  logic [31:0] prdata, io_base, io_limit, req_addr;
  logic        pready, pslverr, fwd_valid, fwd_hit, par_en, sys_en, req_valid;
  logic [5:0]  evt;
  int          fails = 0;
  int          checks = 0;
  int          cyc = 0;

  biw_far_side i_far (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .fire_i(fire),
    .look_i(look), .look_addr_i(look_addr), .evt_o(evt), .io_req_valid_o(req_valid),
    .io_req_addr_o(req_addr));
  biw_bank i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .parity_err_evt_i(evt[0]), .cpl_abort_sent_i(evt[1]), .cpl_abort_rcvd_i(evt[2]),
    .cpl_ur_rcvd_i(evt[3]), .err_msg_sent_i(evt[4]), .poisoned_rcvd_i(evt[5]),
    .io_req_valid_i(req_valid), .io_req_addr_i(req_addr), .io_fwd_valid_o(fwd_valid),
    .io_fwd_hit_o(fwd_hit), .io_base_o(io_base), .io_limit_o(io_limit),
    .parity_resp_en_o(par_en), .system_error_report_enable_o(sys_en));

  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic test_done();
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      test_done();
    end
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one APB transfer; error flag and read data compared at the completing edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic xe, input logic [31:0] x);
    @(posedge core_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge core_clk_i);
    penable <= 1'b1;
    @(posedge core_clk_i);
    // no local limit: a hung wait ends at the cycle timeout as a failure
    while (pready !== 1'b1) begin
      @(posedge core_clk_i);
    end
    chk({pslverr, prdata}, {xe, x});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic lookup(input logic [31:0] a, input logic xh);
    @(posedge core_clk_i);
    look      <= 1'b1;
    look_addr <= a;
    @(posedge core_clk_i);
    look <= 1'b0;
    while (fwd_valid !== 1'b1) begin
      @(posedge core_clk_i);
    end
    chk({32'h0000_0000, fwd_hit}, {32'h0000_0000, xh});
  endtask

  task automatic pulse_all();
    @(posedge core_clk_i);
    fire <= 6'h3f;
    @(posedge core_clk_i);
    fire <= 6'h00;
    repeat (2) @(posedge core_clk_i);
  endtask

  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    chk({1'b0, io_base}, 33'h0_0000_0000);
    chk({1'b0, io_limit}, 33'h0_0000_0fff);
    acc(1'b0, OFS_IO_STATUS, 32'h0000_0000, 4'hf, 1'b0, 32'h0000_0101);
    acc(1'b0, OFS_IO_UPPER, 32'h0000_0000, 4'hf, 1'b0, 32'h0000_0000);
    acc(1'b0, OFS_BRG_CTRL, 32'h0000_0000, 4'hf, 1'b0, 32'h0000_0000);
    // ones into constant and reserved places must not stick
    acc(1'b1, OFS_IO_STATUS, 32'h07ff_7f3f, 4'hf, 1'b0, 32'h0000_0000);
    acc(1'b0, OFS_IO_STATUS, 32'h0000_0000, 4'hf, 1'b0, 32'h0000_7131);
    acc(1'b1, OFS_IO_UPPER, 32'h0002_0001, 4'hf, 1'b0, 32'h0000_0000);
    acc(1'b1, OFS_IO_UPPER, 32'hffff_ffff, 4'h0, 1'b0, 32'h0000_0000);
    acc(1'b0, OFS_IO_UPPER, 32'h0000_0000, 4'hf, 1'b0, 32'h0002_0001);
    repeat (2) @(posedge core_clk_i);
    chk({1'b0, io_base}, 33'h0_0001_3000);
    chk({1'b0, io_limit}, 33'h0_0002_7fff);
    lookup(32'h0001_2fff, 1'b0);
    lookup(32'h0001_3000, 1'b1);
    lookup(32'h0002_7fff, 1'b1);
    lookup(32'h0002_8000, 1'b0);
    // enables off: bits 24 and 30 must stay clear
    pulse_all();
    acc(1'b0, OFS_IO_STATUS, 32'h0000_0000, 4'hf, 1'b0, 32'hb800_7131);
    acc(1'b1, OFS_IO_STATUS, 32'hff00_0000, 4'h8, 1'b0, 32'h0000_0000);
    acc(1'b0, OFS_IO_STATUS, 32'h0000_0000, 4'hf, 1'b0, 32'h3800_7131);
    acc(1'b1, OFS_BRG_CTRL, 32'h0003_0000, 4'hf, 1'b0, 32'h0000_0000);
    // the enables land on the completing edge, so look one edge later
    @(posedge core_clk_i);
    chk({31'h0000_0000, sys_en, par_en}, 33'h0_0000_0003);
    acc(1'b0, OFS_BRG_CTRL, 32'h0000_0000, 4'hf, 1'b0, 32'h0003_0000);
    pulse_all();
    acc(1'b0, OFS_IO_STATUS, 32'h0000_0000, 4'hf, 1'b0, 32'hf900_7131);
    acc(1'b1, OFS_IO_STATUS, 32'h0000_0000, 4'h8, 1'b0, 32'h0000_0000);
    acc(1'b0, OFS_IO_STATUS, 32'h0000_0000, 4'hf, 1'b0, 32'hf900_7131);
    acc(1'b1, OFS_IO_STATUS, 32'hff00_0000, 4'h8, 1'b0, 32'h0000_0000);
    acc(1'b0, OFS_IO_STATUS, 32'h0000_0000, 4'hf, 1'b0, 32'h3800_7131);
    acc(1'b0, 8'h20, 32'h0000_0000, 4'hf, 1'b1, 32'h0000_0000);
    acc(1'b1, 8'h20, 32'hffff_ffff, 4'hf, 1'b1, 32'h0000_0000);
    // a second reset must clear the read-only flags and the enables too
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    chk({31'h0000_0000, sys_en, par_en}, 33'h0_0000_0000);
    acc(1'b0, OFS_IO_STATUS, 32'h0000_0000, 4'hf, 1'b0, 32'h0000_0101);
    test_done();
  end
endmodule // tb_top

bind biw_bank biw_bank_chk i_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .io_req_valid_i(io_req_valid_i), .io_req_addr_i(io_req_addr_i),
  .io_fwd_valid_o(io_fwd_valid_o), .io_fwd_hit_o(io_fwd_hit_o), .io_base_o(io_base_o),
  .io_limit_o(io_limit_o), .parity_resp_en_o(parity_resp_en_o),
  .system_error_report_enable_o(system_error_report_enable_o));
`default_nettype wire

//--- verilog/biw_bank.sv
// APB register bank for the bridge I/O window and downstream status
`timescale 1ns/10ps
`default_nettype none
module biw_bank
  import biw_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  // APB slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [APB_ADDR_W-1:0] paddr_i,
  input  wire logic [APB_DATA_W-1:0] pwdata_i,
  input  wire logic [3:0]            pstrb_i,
  output var  logic [APB_DATA_W-1:0] prdata_o,
  output var  logic                  pready_o,
  output var  logic                  pslverr_o,
  // downstream transaction events
  input  wire logic                  parity_err_evt_i,
  input  wire logic                  cpl_abort_sent_i,
  input  wire logic                  cpl_abort_rcvd_i,
  input  wire logic                  cpl_ur_rcvd_i,
  input  wire logic                  err_msg_sent_i,
  input  wire logic                  poisoned_rcvd_i,
  // I/O forwarding decision
  input  wire logic                  io_req_valid_i,
  input  wire logic [31:0]           io_req_addr_i,
  output var  logic                  io_fwd_valid_o,
  output var  logic                  io_fwd_hit_o,
  output var  logic [31:0]           io_base_o,
  output var  logic [31:0]           io_limit_o,
  // enables seen by the transaction logic
  output var  logic                  parity_resp_en_o,
  output var  logic                  system_error_report_enable_o
);

  biw_apb_state_t          state;
  biw_apb_state_t          next_state;

  logic [3:0]              io_base_nib;
  logic [3:0]              io_limit_nib;
  logic [15:0]             io_base_upper;
  logic [15:0]             io_limit_upper;
  logic                    perr_resp_en;
  logic                    system_error_report_enable;

  logic [NUM_FLAGS-1:0]    flag_set;
  logic [NUM_FLAGS-1:0]    flag_clr;
  logic [NUM_FLAGS-1:0]    flag_q;

  logic [15:0]             io_window_word;
  logic [15:0]             downstream_side_status;

  logic                    setup_phase;
  logic                    access_done;
  logic                    wr_done;
  logic                    sel_io_status;
  logic                    sel_io_upper;
  logic                    sel_brg_ctrl;
  logic                    addr_mapped;
  logic                    access_phase;
  logic [3:0]              wr_lane_status;
  logic [3:0]              wr_lane_upper;
  logic [3:0]              wr_lane_ctrl;

  logic [APB_DATA_W-1:0]   next_rdata;
  logic                    next_slverr;

  logic [31:0]             win_base;
  logic [31:0]             win_limit;
  logic                    win_hit;

  // ------------------------------------------------------------------
  // APB phase tracking
  // ------------------------------------------------------------------

  assign setup_phase  = psel_i && !penable_i;
  assign access_phase = psel_i && penable_i;

  always_comb begin
    next_state = state;
    unique case (state)
      BIW_IDLE: begin
        if (setup_phase) begin
          next_state = BIW_ACCESS;
        end
      end
      BIW_ACCESS: begin
        if (access_phase) begin
          next_state = BIW_IDLE;
        end
      end
      default: begin
        next_state = BIW_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= BIW_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // read data is captured in setup, so the access phase always completes at once
  always_comb begin
    pready_o = (state == BIW_ACCESS) && access_phase;
  end

  assign access_done = pready_o;
  assign wr_done     = access_done && pwrite_i;

  // ------------------------------------------------------------------
  // address decode on the word address only; paddr_i[1:0] are ignored
  // ------------------------------------------------------------------

  assign sel_io_status = (paddr_i[APB_ADDR_W-1:2] == OFS_IO_STATUS[APB_ADDR_W-1:2]);
  assign sel_io_upper  = (paddr_i[APB_ADDR_W-1:2] == OFS_IO_UPPER[APB_ADDR_W-1:2]);
  assign sel_brg_ctrl  = (paddr_i[APB_ADDR_W-1:2] == OFS_BRG_CTRL[APB_ADDR_W-1:2]);
  assign addr_mapped   = sel_io_status || sel_io_upper || sel_brg_ctrl;

  // word map: 1ch window nibbles and status flags, 30h upper halves
  // of base (low) and limit (high), 3ch the two report enables;
  // every other word answers with pslverr and writes nothing
  // a lane is written only on the completing access edge, so a write
  // cannot land twice even if the master stretches its access phase
  always_comb begin
    wr_lane_status = 4'h0;
    wr_lane_upper  = 4'h0;
    wr_lane_ctrl   = 4'h0;
    if (wr_done && addr_mapped) begin
      if (sel_io_status) begin
        wr_lane_status = pstrb_i;
      end
      if (sel_io_upper) begin
        wr_lane_upper = pstrb_i;
      end
      if (sel_brg_ctrl) begin
        wr_lane_ctrl = pstrb_i;
      end
    end
  end

  // ------------------------------------------------------------------
  // writable window fields
  // ------------------------------------------------------------------

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_base_nib <= IO_NIB_RST;
    end else if (wr_lane_status[0]) begin
      io_base_nib <= pwdata_i[IO_BASE_LSB +: 4]; // [RULE_02]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_limit_nib <= IO_NIB_RST;
    end else if (wr_lane_status[1]) begin
      io_limit_nib <= pwdata_i[IO_LIMIT_LSB +: 4]; // [RULE_04]
    end
  end

  // upper halves of the bounds, one byte lane at a time
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_base_upper <= UPPER_RST;
    end else begin
      if (wr_lane_upper[0]) begin
        io_base_upper[7:0] <= pwdata_i[UPPER_BASE_LSB +: 8]; // [RULE_06]
      end
      if (wr_lane_upper[1]) begin
        io_base_upper[15:8] <= pwdata_i[UPPER_BASE_LSB + 8 +: 8]; // [RULE_06]
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_limit_upper <= UPPER_RST;
    end else begin
      if (wr_lane_upper[2]) begin
        io_limit_upper[7:0] <= pwdata_i[UPPER_LIMIT_LSB +: 8]; // [RULE_06]
      end
      if (wr_lane_upper[3]) begin
        io_limit_upper[15:8] <= pwdata_i[UPPER_LIMIT_LSB + 8 +: 8]; // [RULE_06]
      end
    end
  end

  // ------------------------------------------------------------------
  // bridge control enables
  // ------------------------------------------------------------------

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      perr_resp_en <= CTRL_EN_RST;
    end else if (wr_lane_ctrl[2]) begin
      perr_resp_en <= pwdata_i[CTRL_PERR_EN_POS];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      system_error_report_enable <= CTRL_EN_RST;
    end else if (wr_lane_ctrl[2]) begin
      system_error_report_enable <= pwdata_i[CTRL_SERR_EN_POS];
    end
  end

  assign parity_resp_en_o             = perr_resp_en;
  assign system_error_report_enable_o = system_error_report_enable;

  // ------------------------------------------------------------------
  // sticky downstream status flags
  // ------------------------------------------------------------------

  always_comb begin
    flag_set           = '0;
    flag_set[FLG_MDPE] = parity_err_evt_i && perr_resp_en;               // [RULE_09] [RULE_10]
    flag_set[FLG_STA]  = cpl_abort_sent_i;                               // [RULE_11]
    flag_set[FLG_RTA]  = cpl_abort_rcvd_i;                               // [RULE_12]
    flag_set[FLG_RMA]  = cpl_ur_rcvd_i;                                  // [RULE_13]
    flag_set[FLG_RSE]  = err_msg_sent_i && system_error_report_enable;   // [RULE_14]
    flag_set[FLG_DPE]  = poisoned_rcvd_i;                                // [RULE_15]
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      // only the top byte lane carries the flags
      assign flag_clr[gi] = wr_lane_status[3] && pwdata_i[FLAG_POS[gi]]; // [RULE_16]

      biw_status_flag #(
        .CLEARABLE (FLAG_W1C[gi])
      ) u_flag (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .set_i      (flag_set[gi]),
        .clr_i      (flag_clr[gi]),
        .flag_o     (flag_q[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // read-back images
  // ------------------------------------------------------------------

  always_comb begin
    io_window_word                                = '0;
    io_window_word[IO_BASE_IND_LSB +: 4]          = IO_ADDR_CAP;  // [RULE_01]
    io_window_word[IO_BASE_LSB +: 4]              = io_base_nib;
    io_window_word[IO_LIMIT_IND_LSB +: 4]         = IO_ADDR_CAP;  // [RULE_01]
    io_window_word[IO_LIMIT_LSB +: 4]             = io_limit_nib;
  end

  // bits not holding a flag (legacy timing, reserved) stay zero
  always_comb begin
    downstream_side_status = '0; // [RULE_08] [RULE_17]
    for (int i = 0; i < NUM_FLAGS; i++) begin
      downstream_side_status[FLAG_POS[i] - 16] = flag_q[i];
    end
  end

  always_comb begin
    next_rdata  = '0;
    next_slverr = 1'b0;
    if (sel_io_status) begin
      next_rdata = {downstream_side_status, io_window_word};
    end else if (sel_io_upper) begin
      next_rdata[UPPER_BASE_LSB +: 16]  = io_base_upper;
      next_rdata[UPPER_LIMIT_LSB +: 16] = io_limit_upper;
    end else if (sel_brg_ctrl) begin
      next_rdata[CTRL_PERR_EN_POS] = perr_resp_en;
      next_rdata[CTRL_SERR_EN_POS] = system_error_report_enable;
    end else begin
      next_slverr = 1'b1;
    end
  end

  // snapshot taken in setup; a flag set during access shows on the next read
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= '0;
    end else if (setup_phase && !pwrite_i) begin
      prdata_o <= next_rdata;
    end else if (setup_phase) begin
      prdata_o <= '0;
    end
  end

  // unmapped accesses answer with an error and change nothing
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pslverr_o <= 1'b0;
    end else if (setup_phase) begin
      pslverr_o <= next_slverr;
    end
  end

  // ------------------------------------------------------------------
  // I/O forwarding window
  // ------------------------------------------------------------------

  biw_io_range u_range (
    .base_nib_i    (io_base_nib),
    .limit_nib_i   (io_limit_nib),
    .base_upper_i  (io_base_upper),
    .limit_upper_i (io_limit_upper),
    .addr_i        (io_req_addr_i),
    .base_o        (win_base),
    .limit_o       (win_limit),
    .hit_o         (win_hit)
  );

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_fwd_valid_o <= 1'b0;
    end else begin
      io_fwd_valid_o <= io_req_valid_i;
    end
  end

  // hit is only meaningful alongside valid; held low otherwise
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_fwd_hit_o <= 1'b0;
    end else begin
      io_fwd_hit_o <= io_req_valid_i && win_hit; // [RULE_07]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_base_o <= '0;
    end else begin
      io_base_o <= win_base;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_limit_o <= '0;
    end else begin
      io_limit_o <= win_limit;
    end
  end

endmodule // biw_bank
`default_nettype wire

//--- verilog/biw_io_range.sv
// assembles the 32-bit I/O window bounds and compares an address against them
`timescale 1ns/10ps
`default_nettype none
module biw_io_range
  import biw_pkg::*;
(
  input  wire logic [3:0]  base_nib_i,
  input  wire logic [3:0]  limit_nib_i,
  input  wire logic [15:0] base_upper_i,
  input  wire logic [15:0] limit_upper_i,
  input  wire logic [31:0] addr_i,
  output var  logic [31:0] base_o,
  output var  logic [31:0] limit_o,
  output var  logic        hit_o
);

  always_comb begin
    base_o  = {base_upper_i, base_nib_i, 12'h000};   // [RULE_03] [RULE_06]
    limit_o = {limit_upper_i, limit_nib_i, 12'hfff}; // [RULE_05] [RULE_06]
    // a limit below the base opens no window at all
    hit_o   = (addr_i >= base_o) && (addr_i <= limit_o); // [RULE_07]
  end

endmodule // biw_io_range
`default_nettype wire

//--- verilog/biw_pkg.sv
// constants and register layout of the bridge I/O window and downstream status bank
// Behaviour
// [RULE_01] both window indicators read constant 1h
// [RULE_02] base nibble bits 7:4 writable, resets zero
// [RULE_03] lower bound low twelve bits zero
// [RULE_04] limit nibble bits 15:12 writable, resets zero
// [RULE_05] upper bound low twelve bits ones
// [RULE_06] bits 31:16 from upper registers
// [RULE_07] bounds decide I/O forwarding
// [RULE_08] bits 21, 23, 26:25 read zero
// [RULE_09] parity error sets bit 24
// [RULE_10] bit 24 never set without response enable
// [RULE_11] sent completer abort sets bit 27
// [RULE_12] received completer abort sets bit 28
// [RULE_13] received unsupported request sets bit 29
// [RULE_14] error message with enable sets 30
// [RULE_15] poisoned packet received sets bit 31
// [RULE_16] bits 24, 30, 31 write-one-to-clear
// [RULE_17] reserved bits read zero, ignore writes
package biw_pkg;

  localparam int          APB_ADDR_W        = 8;
  localparam int          APB_DATA_W        = 32;

  // byte addresses of the register words
  localparam logic [7:0]  OFS_IO_STATUS     = 8'h1c;
  localparam logic [7:0]  OFS_IO_UPPER      = 8'h30;
  localparam logic [7:0]  OFS_BRG_CTRL      = 8'h3c;

  // window fields inside the status word
  localparam int          IO_BASE_IND_LSB   = 0;
  localparam int          IO_BASE_LSB       = 4;
  localparam int          IO_LIMIT_IND_LSB  = 8;
  localparam int          IO_LIMIT_LSB      = 12;
  localparam logic [3:0]  IO_ADDR_CAP       = 4'h1;
  localparam logic [3:0]  IO_NIB_RST        = 4'h0;

  // upper-16 word: base in low half, limit in high half
  localparam int          UPPER_BASE_LSB    = 0;
  localparam int          UPPER_LIMIT_LSB   = 16;
  localparam logic [15:0] UPPER_RST         = 16'h0000;

  // bridge control word
  localparam int          CTRL_PERR_EN_POS  = 16;
  localparam int          CTRL_SERR_EN_POS  = 17;
  localparam logic        CTRL_EN_RST       = 1'b0;

  // sticky downstream status flags
  localparam int          NUM_FLAGS         = 6;
  localparam int          FLAG_POS [NUM_FLAGS] = '{24, 27, 28, 29, 30, 31};
  localparam logic [NUM_FLAGS-1:0] FLAG_W1C = 6'b11_0001;
  localparam logic        FLAG_RST          = 1'b0;

  localparam int          FLG_MDPE          = 0;
  localparam int          FLG_STA           = 1;
  localparam int          FLG_RTA           = 2;
  localparam int          FLG_RMA           = 3;
  localparam int          FLG_RSE           = 4;
  localparam int          FLG_DPE           = 5;

  typedef enum logic [1:0] {
    BIW_IDLE   = 2'b01,
    BIW_ACCESS = 2'b10
  } biw_apb_state_t;

endpackage

//--- verilog/biw_status_flag.sv
// one sticky status flag with optional write-one-to-clear
`timescale 1ns/10ps
`default_nettype none
module biw_status_flag
  import biw_pkg::*;
#(
  parameter bit CLEARABLE = 1'b1
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output var  logic flag_o
);

  // a set in the clearing cycle wins so no event is lost
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= FLAG_RST;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (CLEARABLE && clr_i) begin // [RULE_16]
      flag_o <= 1'b0;
    end
  end

endmodule // biw_status_flag
`default_nettype wire
